// ===== hw/fer_erase_check.sv
// Flash erase request checker, erase sequencer and pass/fail result byte
//
// Contract
// - Protect flag sets bit 6, blocks erase
// - Erase fail or register change sets bit 5
// - Boot array selected gives bit 5, no erase
// - Key not 5A sets bit 4
// - Block out of range sets bit 3
// - Bits 2 and 1 read zero
// - Bit 0 zero on success, one on error
// - One block 0..15; others are errors
// - Bit 7 reads zero
`timescale 1ns/1ps
module fer_erase_check #(
	parameter int BLOCKS = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic eraseStart,                // One-cycle erase request pulse
	input wire fer_pkg::fer_req_s eraseReq,    // Block, key and array select
	input wire logic flashProtectFlag,          // Error protection flag level
	input wire logic regsAltered,               // Flash registers changed by user branch
	output logic eraseBusy,                     // Request in progress
	output logic [BLOCKS-1:0] blockEraseSel,    // One-hot block erase strobe
	input wire logic eraseDone,                 // Array reports erase end
	input wire logic eraseFail,                 // Array reports erase failure
	output logic resultValid,                   // One-cycle pulse with new result
	output logic [7:0] passFailResult           // Pass/fail result byte
);

	////////////////////////////////////////////////////////////////////////////
	// Request checks

	// Registered copy of the request, held for the whole sequence
	fer_pkg::fer_req_s req_r;
	fer_pkg::fer_state_e state_r, state_nxt;
	logic eraseErr_r;
	logic [7:0] passFailResult_r;
	logic [BLOCKS-1:0] blockEraseSel_r;

	// Checks are combinational on the held request
	// The protect flag is read live, so a late assertion still shows in bit 6
	wire logic protErr = flashProtectFlag;
	wire logic bootSel = (req_r.arraySel == fer_pkg::BOOT_ARRAY_SEL);
	wire logic keyErr = (req_r.keyReg != fer_pkg::KEY_OK);
	wire logic blockErr = (req_r.blockNum > fer_pkg::LAST_BLOCK);
	// Any failed pre-check refuses the erase; boot array never erased here
	wire logic refuse = protErr | bootSel | keyErr | blockErr;

	// Decoded one-hot strobe; an out-of-range number yields no bit
	// Out-of-range numbers therefore never strobe the array
	function automatic logic [BLOCKS-1:0] decodeBlock(input logic [7:0] num);
		logic [BLOCKS-1:0] v;
		v = '0;
		if (num < 8'(BLOCKS)) begin
			v[num[3:0]] = 1'b1;
		end
		return v;
	endfunction

	// Result byte assembly; reserved bits forced to zero
	function automatic logic [7:0] buildResult(input logic protBit, input logic timeBit,
		input logic keyBit, input logic blkBit);
		logic [7:0] r;
		r = fer_pkg::RESULT_RST;
		r[fer_pkg::PROT_MODE_BIT] = protBit;
		r[fer_pkg::ERASE_TIME_BIT] = timeBit;
		r[fer_pkg::KEY_ERR_BIT] = keyBit;
		r[fer_pkg::BLOCK_ERR_BIT] = blkBit;
		r[fer_pkg::SUCC_FAIL_BIT] = protBit | timeBit | keyBit | blkBit;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	// Four one-hot states; CHECK decides, ERASE waits for the array
	// Next-state logic
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			fer_pkg::ST_IDLE: begin
				if (eraseStart) begin
					state_nxt = fer_pkg::ST_CHECK;
				end
			end
			fer_pkg::ST_CHECK: begin
				// Refused requests skip the array entirely
				state_nxt = refuse ? fer_pkg::ST_DONE : fer_pkg::ST_ERASE;
			end
			fer_pkg::ST_ERASE: begin
				if (eraseDone) begin
					state_nxt = fer_pkg::ST_DONE;
				end
			end
			fer_pkg::ST_DONE: begin
				// One settling cycle lets the result byte see the final sticky error
				state_nxt = fer_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = fer_pkg::ST_IDLE;
			end
		endcase
	end

	// Erase-time error: array failure or altered registers while erasing
	wire logic timeErrNow = (state_r == fer_pkg::ST_ERASE) & (eraseFail | regsAltered);

	// State and request capture
	// Capture only when idle; a start while busy is dropped silently
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= fer_pkg::ST_IDLE;
			req_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_r == fer_pkg::ST_IDLE && eraseStart) begin
				req_r <= eraseReq;
			end
		end
	end

	// Sticky erase-time error for the current request
	// Cleared in idle, so a failure never leaks into the next request
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			eraseErr_r <= 1'b0;
		end else if (state_r == fer_pkg::ST_IDLE) begin
			eraseErr_r <= 1'b0;
		end else if (timeErrNow) begin
			eraseErr_r <= 1'b1;
		end
	end

	// Block strobe held during the erase phase only
	// Registered so the strobe never glitches while the decode settles
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			blockEraseSel_r <= fer_pkg::BLOCK_SEL_RST[BLOCKS-1:0];
		end else if (state_nxt == fer_pkg::ST_ERASE) begin
			blockEraseSel_r <= decodeBlock(req_r.blockNum);
		end else begin
			blockEraseSel_r <= '0;
		end
	end

	// Result byte, updated when the sequence ends; holds until the next request ends
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			passFailResult_r <= fer_pkg::RESULT_RST;
		end else if (state_r == fer_pkg::ST_DONE) begin
			passFailResult_r <= buildResult(protErr, eraseErr_r | bootSel, keyErr, blockErr);
		end
	end

	// Pulse in the same cycle the result is written, both set from the DONE state
	logic resultValid_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			resultValid_r <= 1'b0;
		end else begin
			resultValid_r <= (state_r == fer_pkg::ST_DONE);
		end
	end

	// Busy comes straight from the state, so it drops the cycle the result lands
	assign eraseBusy = (state_r != fer_pkg::ST_IDLE);
	assign blockEraseSel = blockEraseSel_r;
	assign passFailResult = passFailResult_r;
	assign resultValid = resultValid_r;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	// Every property runs on the system clock and is muted while reset is low
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Reserved positions never carry a flag
	rsv_zero_a: assert property (passFailResult[fer_pkg::RSV7_BIT] == 1'b0 &&
		passFailResult[2:1] == 2'b00) else $error("reserved result bits not zero");
	// Success/fail is exactly the OR of the four error flags
	succ_or_a: assert property (passFailResult[fer_pkg::SUCC_FAIL_BIT] ==
		(|passFailResult[6:3])) else $error("success bit disagrees with error flags");
	// A refused request leaves the array alone and still reports
	refuse_noerase_a: assert property ((state_r == fer_pkg::ST_CHECK && refuse) |=>
		blockEraseSel == '0 ##1 resultValid) else $error("refused request touched array");
	// Key flag follows the captured key
	key_flag_a: assert property ((state_r == fer_pkg::ST_DONE) |=>
		passFailResult[fer_pkg::KEY_ERR_BIT] == (req_r.keyReg != fer_pkg::KEY_OK))
		else $error("key flag wrong");
	// Block flag follows the captured block number
	block_flag_a: assert property ((state_r == fer_pkg::ST_DONE) |=>
		passFailResult[fer_pkg::BLOCK_ERR_BIT] == (req_r.blockNum > fer_pkg::LAST_BLOCK))
		else $error("block flag wrong");
	// Selecting the boot array is reported as an erase-time error
	boot_sel_a: assert property ((state_r == fer_pkg::ST_DONE && bootSel) |=>
		passFailResult[fer_pkg::ERASE_TIME_BIT]) else $error("boot array select not flagged");
	// An array failure reaches the result byte before the next request
	fail_flag_a: assert property ((state_r == fer_pkg::ST_ERASE && eraseFail) |->
		##[1:1000] (resultValid && passFailResult[fer_pkg::ERASE_TIME_BIT]))
		else $error("erase failure not flagged");
	// Altered flash registers during the erase count as an erase-time error
	alt_flag_a: assert property ((state_r == fer_pkg::ST_ERASE && regsAltered) |->
		##[1:1000] (resultValid && passFailResult[fer_pkg::ERASE_TIME_BIT]))
		else $error("altered registers not flagged");
	// The strobe names one block and only for an accepted request
	onehot_sel_a: assert property ((blockEraseSel != '0) |-> $onehot(blockEraseSel) &&
		!refuse) else $error("bad block strobe");
	// A start seen while busy leaves the captured request untouched
	busy_ignore_a: assert property ((eraseBusy && eraseStart) |=> $stable(req_r))
		else $error("request changed while busy");
	// The protect flag seen at the end of a request shows in the result
	prot_flag_a: assert property ((state_r == fer_pkg::ST_DONE && flashProtectFlag) |=>
		passFailResult[fer_pkg::PROT_MODE_BIT]) else $error("protect flag not reported");

	// Main scenarios: clean erase, key and boot refusals, all errors, busy start
	ok_erase_c: cover property (eraseStart ##[1:20] (resultValid && passFailResult == 8'h00));
	key_fail_c: cover property (resultValid && passFailResult[fer_pkg::KEY_ERR_BIT]);
	boot_fail_c: cover property (resultValid && passFailResult[fer_pkg::ERASE_TIME_BIT]);
	all_fail_c: cover property (resultValid && passFailResult == 8'h79);
	busy_start_c: cover property (eraseBusy && eraseStart);
endmodule

// ===== hw/fer_pkg.sv
// Package for the flash erase result checker: constants, types, states
package fer_pkg;
	// Result byte field positions
	localparam int SUCC_FAIL_BIT = 0;
	localparam int BLOCK_ERR_BIT = 3;
	localparam int KEY_ERR_BIT = 4;
	localparam int ERASE_TIME_BIT = 5;
	localparam int PROT_MODE_BIT = 6;
	localparam int RSV7_BIT = 7;
	// Key value that unlocks erasure
	localparam logic [7:0] KEY_OK = 8'h5A;
	// Array select value meaning the user boot array
	localparam logic [7:0] BOOT_ARRAY_SEL = 8'hAA;
	// Highest legal user array block number
	localparam logic [7:0] LAST_BLOCK = 8'h0F;
	// Reset value of the result byte
	localparam logic [7:0] RESULT_RST = 8'h00;
	// Reset value of the block select output
	localparam logic [15:0] BLOCK_SEL_RST = 16'h0000;

	// Erase request from the CPU side
	typedef struct packed {
		logic [7:0] blockNum;   // Erase block number
		logic [7:0] keyReg;     // Protection key register
		logic [7:0] arraySel;   // Array select register
	} fer_req_s;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_CHECK = 4'b0010,
		ST_ERASE = 4'b0100,
		ST_DONE  = 4'b1000
	} fer_state_e;
endpackage

// ===== testbench/fer_array_model.sv
// Behavioural flash array that answers erase strobes
`timescale 1ns/1ps
module fer_array_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [15:0] blockEraseSel,
	input wire logic failMode,
	output logic eraseDone,
	output logic eraseFail
);
	logic [3:0] busyCnt_r; // Cycles spent erasing
	////////////////////////////////////////////////////////////////
	// Erase lasts several cycles so the sequencer has to wait for done
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			busyCnt_r <= 4'h0;
		end else if (blockEraseSel != 16'h0000) begin
			busyCnt_r <= busyCnt_r + 4'h1;
		end else begin
			busyCnt_r <= 4'h0;
		end
	end
	assign eraseDone = (busyCnt_r == 4'h3); // One-cycle end mark
	assign eraseFail = failMode && (blockEraseSel != 16'h0000);
endmodule

// ===== testbench/fer_erase_check_bench.sv
// Self-checking bench for the erase result checker
`timescale 1ns/1ps
module fer_erase_check_bench;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic eraseStart = 1'b0;
	fer_pkg::fer_req_s eraseReq = '0;
	logic flashProtectFlag = 1'b0;
	logic regsAltered = 1'b0;
	logic failMode = 1'b0; // Array reports failure when set
	logic eraseBusy, eraseDone, eraseFail, resultValid;
	logic [15:0] blockEraseSel;
	logic [15:0] sawSel = 16'h0000; // Every select bit seen in one request
	logic [7:0] passFailResult;
	int num_errors = 0;
	int check_count = 0;
	////////////////////////////////////////////////////////////////
	always #20 ref_clk = ~ref_clk;
	// Cleared at each request so a stray strobe cannot hide
	always @(posedge ref_clk) sawSel <= eraseStart ? 16'h0000 : (sawSel | blockEraseSel);
	fer_erase_check dut (.ref_clk(ref_clk), .reset_n(reset_n), .eraseStart(eraseStart),
		.eraseReq(eraseReq), .flashProtectFlag(flashProtectFlag), .regsAltered(regsAltered),
		.eraseBusy(eraseBusy), .blockEraseSel(blockEraseSel), .eraseDone(eraseDone),
		.eraseFail(eraseFail), .resultValid(resultValid), .passFailResult(passFailResult));
	fer_array_model array (.ref_clk(ref_clk), .reset_n(reset_n), .blockEraseSel(blockEraseSel),
		.failMode(failMode), .eraseDone(eraseDone), .eraseFail(eraseFail));
	////////////////////////////////////////////////////////////////
	task checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task checkSel(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One request, held conditions stay put until the result arrives
	task runEr(input logic [7:0] blk, key, arr, input logic prot, alt, fail,
		input logic [7:0] expByte, input logic [15:0] expSel, input logic again);
		int n;
		@(posedge ref_clk);
		eraseStart <= 1'b1;
		eraseReq <= {blk, key, arr};
		flashProtectFlag <= prot;
		regsAltered <= alt;
		failMode <= fail;
		@(posedge ref_clk);
		// Optionally hold start one more cycle with a bad request that must be dropped
		eraseStart <= again;
		if (again) begin
			eraseReq <= {8'hFF, 8'h00, 8'hAA};
			@(posedge ref_clk);
			eraseStart <= 1'b0;
		end
		@(negedge ref_clk);
		checkByte("busy", 8'h01, {7'h00, eraseBusy});
		n = 0;
		// Bounded wait, sampled on the falling edge where outputs are settled
		while (resultValid !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		checkByte("valid", 8'h01, {7'h00, resultValid});
		checkByte("result", expByte, passFailResult);
		checkSel("select", expSel, sawSel);
		checkByte("idle", 8'h00, {7'h00, eraseBusy});
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog: the whole sequence needs well under 200 cycles
	initial begin
		#100us;
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		checkByte("reset result", 8'h00, passFailResult);
		checkSel("reset select", 16'h0000, blockEraseSel);
		checkByte("reset flags", 8'h00, {6'h00, eraseBusy, resultValid});
		@(posedge ref_clk);
		reset_n <= 1'b1;
		runEr(8'h00, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0001, 1'b0);
		runEr(8'h0F, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 16'h8000, 1'b0);
		runEr(8'h10, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0, 8'h09, 16'h0000, 1'b0);
		runEr(8'h03, 8'h5B, 8'h00, 1'b0, 1'b0, 1'b0, 8'h11, 16'h0000, 1'b0);
		runEr(8'h04, 8'h5A, 8'h00, 1'b1, 1'b0, 1'b0, 8'h41, 16'h0000, 1'b0);
		runEr(8'h05, 8'h5A, 8'hAA, 1'b0, 1'b0, 1'b0, 8'h21, 16'h0000, 1'b0);
		runEr(8'h05, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b1, 8'h21, 16'h0020, 1'b0);
		runEr(8'h05, 8'h5A, 8'h00, 1'b0, 1'b1, 1'b0, 8'h21, 16'h0020, 1'b0);
		runEr(8'hFF, 8'h00, 8'hAA, 1'b1, 1'b0, 1'b0, 8'h79, 16'h0000, 1'b0);
		runEr(8'h07, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0080, 1'b1);
		wrap_up;
	end
endmodule
